// ---- rtl/gpk_pkg.sv ----
// Types shared by the GPIO port block and its users.
// Assumes a single 16-bit data path for all locations.
`default_nettype none

package gpk_pkg;

    // Locations reachable through the command port
    typedef enum logic [2:0] {
        LOC_PIN_DATA,
        LOC_OUT_BUF,
        LOC_DIR,
        LOC_ATTR,
        LOC_ALT_EN,
        LOC_KC_EN,
        LOC_LATCH,
        LOC_KC_CTRL
    } gpk_loc_t;

    // One access from the processor side
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [1:0]  port;
        gpk_loc_t    loc;
        logic [15:0] wdata;
    } gpk_cmd_t;

endpackage : gpk_pkg

`default_nettype wire

// ---- rtl/gpk_port.sv ----
// Four 16-bit GPIO ports with alternate-function override on ports A to C and key-change
// wake detection on port A bits 15:8.
// Assumes pads and peripherals are synchronous to i_sys_clk; pad resolution
// (pull resistors, three-state) is done outside from the drive outputs.
`timescale 1ns/1ns
`default_nettype none
`include "gpk_regs.svh"

module gpk_port (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_b,
    input  wire gpk_pkg::gpk_cmd_t i_cmd,
    input  wire logic [3:0][15:0]  i_pad_in,
    input  wire logic [3:0][15:0]  i_alt_out,
    input  wire logic [3:0][15:0]  i_alt_oe,
    output var  logic [15:0]       o_rd_data,
    output var  logic              o_rd_valid,
    output var  logic [3:0][15:0]  o_pad_out,
    output var  logic [3:0][15:0]  o_pad_oe,
    output var  logic [3:0][15:0]  o_pull_up,
    output var  logic [3:0][15:0]  o_pull_dn,
    output var  logic [3:0][15:0]  o_alt_in,
    output var  logic [3:0][15:0]  o_alt_function_enable,
    output var  logic              o_key_change_flag,
    output var  logic              o_key_irq,
    output var  logic              o_wakeup
);
    import gpk_pkg::*;

    // Pin drive decode: {out, oe, pull up, pull down}
    function automatic logic [3:0] pin_drive(input logic dir,
                                             input logic attr,
                                             input logic buf_bit);
        logic [3:0] r;
        r = 4'h0;
        if (dir)
            r = {(attr ? buf_bit : ~buf_bit), 1'b1, 2'b00};
        else if (!attr)
            r = {2'b00, buf_bit, ~buf_bit};
        else
            r = 4'h0;
        return r;
    endfunction : pin_drive

    // Settings 000, 001 and 010 allow wake
    function automatic logic wake_ok(input logic dir,
                                     input logic attr,
                                     input logic buf_bit);
        return !dir && !(attr && buf_bit);
    endfunction : wake_ok

    logic [3:0][15:0] dir_q,  dir_d;
    logic [3:0][15:0] attr_q, attr_d;
    logic [3:0][15:0] buf_q,  buf_d;
    logic [3:0][15:0] alt_q,  alt_d;
    logic [7:0]       kcen_q, kcen_d;
    logic             ie_q,   ie_d;
    logic [15:0]      rd_q,   rd_d;
    logic             rdv_q,  rdv_d;
    logic [3:0][15:0] pout_q, pout_d;
    logic [3:0][15:0] poe_q,  poe_d;
    logic [3:0][15:0] pu_q,   pu_d;
    logic [3:0][15:0] pd_q,   pd_d;
    logic [3:0][15:0] ain_q,  ain_d;
    logic [7:0]       sync1_q, sync2_q;
    logic [7:0]       ref_q,  ref_d;
    logic             mis_q,  mis_d;
    logic             flag_q, flag_d;
    logic             irq_q,  irq_d;
    logic [7:0]       elig;
    logic             wr_hit, rd_hit;

    assign wr_hit = i_cmd.valid && i_cmd.wr;
    assign rd_hit = i_cmd.valid && !i_cmd.wr;

    // Configuration, buffer and read-back next values
    always_comb
    begin
        dir_d  = dir_q;
        attr_d = attr_q;
        buf_d  = buf_q;
        alt_d  = alt_q;
        kcen_d = kcen_q;
        ie_d   = ie_q;
        rd_d   = rd_q;
        rdv_d  = rd_hit;
        if (wr_hit)
        begin
            case (i_cmd.loc)
                LOC_PIN_DATA: buf_d[i_cmd.port] = i_cmd.wdata;
                LOC_OUT_BUF:  buf_d[i_cmd.port] = i_cmd.wdata;
                LOC_DIR:      dir_d[i_cmd.port] = i_cmd.wdata;
                LOC_ATTR:     attr_d[i_cmd.port] = i_cmd.wdata;
                LOC_ALT_EN:
                    if (i_cmd.port != `GPK_PORT_D)
                        alt_d[i_cmd.port] = i_cmd.wdata;
                LOC_KC_EN:
                    kcen_d = i_cmd.wdata[`GPK_KC_HI:`GPK_KC_LO];
                LOC_KC_CTRL:  ie_d = i_cmd.wdata[`GPK_KC_IE_BIT];
                default:      ie_d = ie_q;
            endcase
        end
        if (rd_hit)
        begin
            case (i_cmd.loc)
                LOC_PIN_DATA: rd_d = i_pad_in[i_cmd.port];
                LOC_OUT_BUF:  rd_d = buf_q[i_cmd.port];
                LOC_DIR:      rd_d = dir_q[i_cmd.port];
                LOC_ATTR:     rd_d = attr_q[i_cmd.port];
                LOC_ALT_EN:   rd_d = alt_q[i_cmd.port];
                LOC_KC_EN:    rd_d = {kcen_q, 8'h00};
                LOC_LATCH:    rd_d = {sync2_q, 8'h00};
                LOC_KC_CTRL:  rd_d = {14'h0000, flag_q, ie_q};
                default:      rd_d = 16'h0000;
            endcase
        end
    end

    // Pad drive, alternate override and peripheral input next values
    always_comb
    begin
        logic [3:0] drv;
        drv   = 4'h0;
        pout_d = '0;
        poe_d  = '0;
        pu_d   = '0;
        pd_d   = '0;
        ain_d  = i_pad_in;
        for (int p = 0; p < 4; p++)
        begin
            for (int b = 0; b < 16; b++)
            begin
                drv = pin_drive(dir_q[p][b], attr_q[p][b], buf_q[p][b]);
                if (alt_q[p][b])
                begin
                    pout_d[p][b] = i_alt_out[p][b];
                    poe_d[p][b]  = i_alt_oe[p][b];
                end
                else
                begin
                    pout_d[p][b] = drv[3];
                    poe_d[p][b]  = drv[2];
                    pu_d[p][b]   = drv[1];
                    pd_d[p][b]   = drv[0];
                end
            end
        end
    end

    // Key-change detection on synchronised port A 15:8
    always_comb
    begin
        ref_d = ref_q;
        if (rd_hit && i_cmd.loc == LOC_LATCH)
            ref_d = sync2_q;
        for (int k = 0; k < 8; k++)
            elig[k] = kcen_q[k] && !alt_q[0][k + `GPK_KC_LO]
                && wake_ok(dir_q[0][k + `GPK_KC_LO],
                           attr_q[0][k + `GPK_KC_LO],
                           buf_q[0][k + `GPK_KC_LO]);
        mis_d  = |((sync2_q ^ ref_q) & elig);
        flag_d = flag_q;
        if (wr_hit && i_cmd.loc == LOC_KC_CTRL
            && i_cmd.wdata[`GPK_KC_CLR_BIT])
            flag_d = 1'b0;
        if (mis_d && !mis_q)
            flag_d = 1'b1;
        irq_d = flag_q && ie_q;
    end

    // State registers
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dir_q   <= {4{`GPK_DIR_RST}};
            attr_q  <= {4{`GPK_ATTR_RST}};
            buf_q   <= {4{`GPK_BUF_RST}};
            alt_q   <= {4{`GPK_ALT_RST}};
            kcen_q  <= `GPK_KCEN_RST;
            ie_q    <= 1'b0;
            rd_q    <= 16'h0000;
            rdv_q   <= 1'b0;
            pout_q  <= '0;
            poe_q   <= '0;
            pu_q    <= '0;
            pd_q    <= '0;
            ain_q   <= '0;
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            ref_q   <= 8'h00;
            mis_q   <= 1'b0;
            flag_q  <= 1'b0;
            irq_q   <= 1'b0;
        end
        else
        begin
            dir_q   <= dir_d;
            attr_q  <= attr_d;
            buf_q   <= buf_d;
            alt_q   <= alt_d;
            kcen_q  <= kcen_d;
            ie_q    <= ie_d;
            rd_q    <= rd_d;
            rdv_q   <= rdv_d;
            pout_q  <= pout_d;
            poe_q   <= poe_d;
            pu_q    <= pu_d;
            pd_q    <= pd_d;
            ain_q   <= ain_d;
            sync1_q <= i_pad_in[0][`GPK_KC_HI:`GPK_KC_LO];
            sync2_q <= sync1_q;
            ref_q   <= ref_d;
            mis_q   <= mis_d;
            flag_q  <= flag_d;
            irq_q   <= irq_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_rd_data             = rd_q;
    assign o_rd_valid            = rdv_q;
    assign o_pad_out             = pout_q;
    assign o_pad_oe              = poe_q;
    assign o_pull_up             = pu_q;
    assign o_pull_dn             = pd_q;
    assign o_alt_in              = ain_q;
    assign o_alt_function_enable = alt_q;
    assign o_key_change_flag     = flag_q;
    assign o_key_irq             = irq_q;
    assign o_wakeup              = mis_q;

    // Checks on drive, access and key-change behaviour
    AST_INV_OUT: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> ((($past(dir_q) & ~$past(attr_q) & ~$past(alt_q))
            & (o_pad_out ^ ~$past(buf_q))) == '0))
        else $error("inverted output mismatch");
    AST_PLAIN_OUT: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> ((($past(dir_q) & $past(attr_q) & ~$past(alt_q))
            & ((o_pad_out ^ $past(buf_q)) | ~o_pad_oe)) == '0))
        else $error("plain output mismatch");
    AST_FLOAT_IN: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> (((~$past(dir_q) & $past(attr_q) & ~$past(alt_q))
            & (o_pad_oe | o_pull_up | o_pull_dn)) == '0))
        else $error("floating input is driven or pulled");
    AST_PULL_SEL: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> (((~$past(dir_q) & ~$past(attr_q) & ~$past(alt_q))
            & ((o_pull_up ^ $past(buf_q)) | (o_pull_dn ^ ~$past(buf_q))))
            == '0))
        else $error("pull selection wrong");
    AST_ALT_WINS: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> (($past(alt_q) & ((o_pad_oe ^ $past(i_alt_oe))
            | o_pull_up | o_pull_dn)) == '0))
        else $error("alternate function not in control");
    AST_ALT_IN: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> o_alt_in == $past(i_pad_in))
        else $error("peripheral input is not the pad level");
    AST_PORT_D: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        alt_q[3] == 16'h0000)
        else $error("port D has alternate enable");
    AST_SAME_WRITE: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (wr_hit && (i_cmd.loc == LOC_PIN_DATA || i_cmd.loc == LOC_OUT_BUF))
        |=> buf_q[$past(i_cmd.port)] == $past(i_cmd.wdata))
        else $error("buffer write lost");
    AST_PIN_READ: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (rd_hit && i_cmd.loc == LOC_PIN_DATA)
        |=> o_rd_valid && o_rd_data == $past(i_pad_in[i_cmd.port]))
        else $error("pin read is not the pad level");
    AST_KC_SET: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(mis_q) |-> flag_q)
        else $error("key change not flagged");
    AST_KC_CLEAR: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (wr_hit && i_cmd.loc == LOC_KC_CTRL
            && i_cmd.wdata[`GPK_KC_CLR_BIT]
            && !(mis_d && !mis_q)) |=> !flag_q)
        else $error("flag not cleared");
    AST_IRQ_GATE: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        o_key_irq |-> $past(ie_q) && $past(flag_q))
        else $error("irq without enable");

endmodule : gpk_port

`default_nettype wire

// ---- rtl/gpk_regs.svh ----
// Constants for the four-port GPIO block: reset values and key-change span.
// Assumes inclusion by the port module only.
`ifndef GPK_REGS_SVH
`define GPK_REGS_SVH

// Reset values give a floating input on every pin
`define GPK_DIR_RST   16'h0000
`define GPK_ATTR_RST  16'hFFFF
`define GPK_BUF_RST   16'h0000
`define GPK_ALT_RST   16'h0000
`define GPK_KCEN_RST  8'h00

// Key-change pins are port A bits 15 down to 8
`define GPK_KC_HI     15
`define GPK_KC_LO     8

// Port indices
`define GPK_PORT_A    2'h0
`define GPK_PORT_D    2'h3

// Bits of the key-change control location
`define GPK_KC_IE_BIT  0
`define GPK_KC_CLR_BIT 1

`endif

// ---- sim/gpk_pad_model.sv ----
// Pad model for the four GPIO ports: pulls, external devices, wander.
// Assumes the bench sets external levels; the block sets drive and pulls.
`timescale 1ns/1ns
`default_nettype none

module gpk_pad_model (
    input  wire logic             i_clk,
    input  wire logic [3:0][15:0] i_pad_out,
    input  wire logic [3:0][15:0] i_pad_oe,
    input  wire logic [3:0][15:0] i_pull_up,
    input  wire logic [3:0][15:0] i_pull_dn,
    input  wire logic [3:0][15:0] i_ext_val,
    input  wire logic [3:0][15:0] i_ext_en,
    output var  logic [3:0][15:0] o_pad
);
    logic [15:0] flt_q = 16'h5A5A;

    // An undriven pad wanders, so a stale level never passes for a value
    always @(posedge i_clk) flt_q <= ~flt_q;

    // Block drive first, then external device, then pulls, else wander
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            for (int b = 0; b < 16; b++)
            begin
                if (i_pad_oe[p][b])
                    o_pad[p][b] = i_pad_out[p][b];
                else if (i_ext_en[p][b])
                    o_pad[p][b] = i_ext_val[p][b];
                else if (i_pull_up[p][b])
                    o_pad[p][b] = 1'b1;
                else if (i_pull_dn[p][b])
                    o_pad[p][b] = 1'b0;
                else
                    o_pad[p][b] = flt_q[b];
            end
        end
    end
endmodule : gpk_pad_model

`default_nettype wire

// ---- sim/gpk_port_tb.sv ----
// Self-checking bench for the four-port GPIO block with key change.
// Assumes the pad model resolves pad levels from the block's controls.
`timescale 1ns/1ns
`default_nettype none

module gpk_port_tb;
    import gpk_pkg::*;
    typedef struct packed {
        logic [2:0] cfg;
        logic       oe, out, pu, pd;
    } gpk_row_t;

    logic             i_sys_clk, i_rst_b, rd_valid, kc_flag, kc_irq, wake;
    gpk_cmd_t         i_cmd;
    logic [3:0][15:0] pad, alt_out, alt_oe, ext_val, ext_en;
    logic [3:0][15:0] pad_out, pad_oe, pull_up, pull_dn, alt_en, alt_in;
    logic [15:0]      rd_data, got;
    int               fails, check_count;
    gpk_row_t         rows [8] = '{7'h01, 7'h12, 7'h20, 7'h30,
                                   7'h4C, 7'h58, 7'h68, 7'h7C};

    gpk_port gpk_port_i (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cmd(i_cmd),
        .i_pad_in(pad), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .o_pull_up(pull_up), .o_pull_dn(pull_dn),
        .o_alt_in(alt_in), .o_alt_function_enable(alt_en),
        .o_key_change_flag(kc_flag), .o_key_irq(kc_irq), .o_wakeup(wake));

    gpk_pad_model gpk_pad_model_i (
        .i_clk(i_sys_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
        .i_pull_up(pull_up), .i_pull_dn(pull_dn), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_pad(pad));

    // Clock at 50 MHz
    initial
    begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // Comparison of words and of single flags
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED at %0t: word %h, want %h", $time, g, e);
        end
    endtask : chk16

    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED at %0t: flag %b, want %b", $time, g, e);
        end
    endtask : chk1

    // Drops any access, then cycles pass, leaving the bench 2 ns after an edge
    task automatic tick(input int n);
        i_cmd.valid = 1'b0;
        repeat (n) @(posedge i_sys_clk);
        #2;
    endtask : tick

    // One access over one taking edge; valid stays up for a following access
    task automatic put(input logic w, input logic [1:0] p, input gpk_loc_t l,
                       input logic [15:0] d);
        i_cmd = '{1'b1, w, p, l, d};
        @(posedge i_sys_clk);
        #2;
    endtask : put

    // Read: answer stands in the cycle after the taking edge
    task automatic rd(input logic [1:0] p, input gpk_loc_t l,
                      output logic [15:0] d);
        put(1'b0, p, l, 16'h0000);
        chk1(rd_valid, 1'b1);
        d = rd_data;
        tick(1);
    endtask : rd

    task automatic wrap_up;
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the expected run
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        i_rst_b = 1'b0;
        i_cmd = '0;
        alt_out = '0;
        alt_oe = '0;
        ext_val = '0;
        ext_en = '0;
        repeat (8) @(posedge i_sys_clk);
        #2 i_rst_b = 1'b1;
        tick(1);
        // Every configuration row on port B as a whole word
        foreach (rows[i])
        begin
            put(1'b1, 2'h1, LOC_DIR, {16{rows[i].cfg[2]}});
            put(1'b1, 2'h1, LOC_ATTR, {16{rows[i].cfg[1]}});
            put(1'b1, 2'h1, LOC_OUT_BUF, {16{rows[i].cfg[0]}});
            tick(2);
            chk16(pad_oe[1], {16{rows[i].oe}});
            chk16(pull_up[1], {16{rows[i].pu}});
            chk16(pull_dn[1], {16{rows[i].pd}});
            if (rows[i].oe)
                chk16(pad_out[1], {16{rows[i].out}});
            rd(2'h1, LOC_OUT_BUF, got);
            chk16(got, {16{rows[i].cfg[0]}});
            rd(2'h1, LOC_PIN_DATA, got);
            if (rows[i].cfg[2:1] != 2'b01)
                chk16(got, {16{rows[i].out | rows[i].pu}});
        end
        // Float 011 becomes high output by direction alone, then data write
        put(1'b1, 2'h2, LOC_OUT_BUF, 16'hFFFF);
        tick(2);
        chk16(pad_oe[2], 16'h0000);
        put(1'b1, 2'h2, LOC_DIR, 16'hFFFF);
        tick(2);
        chk16(pad_oe[2] & pad_out[2], 16'hFFFF);
        put(1'b1, 2'h2, LOC_PIN_DATA, 16'hA5C3);
        rd(2'h2, LOC_OUT_BUF, got);
        chk16(got, 16'hA5C3);
        rd(2'h2, LOC_PIN_DATA, got);
        chk16(got, 16'hA5C3);
        // Alternate function on port A overrides pulls; port D refuses it
        alt_out[0] = 16'h0A00;
        alt_oe[0] = 16'h0C00;
        put(1'b1, 2'h0, LOC_ATTR, 16'h0000);
        put(1'b1, 2'h0, LOC_OUT_BUF, 16'h0F00);
        put(1'b1, 2'h0, LOC_ALT_EN, 16'h0F00);
        put(1'b1, 2'h3, LOC_ALT_EN, 16'hFFFF);
        tick(2);
        chk16(alt_en[0], 16'h0F00);
        chk16(pad_oe[0] & 16'h0F00, 16'h0C00);
        chk16(pad_out[0] & 16'h0C00, 16'h0800);
        chk16(pull_up[0] & 16'h0F00, 16'h0000);
        chk16(alt_in[0] & 16'h0C00, 16'h0800);
        chk16(alt_en[3], 16'h0000);
        rd(2'h3, LOC_ALT_EN, got);
        chk16(got, 16'h0000);
        // Key change on port A bits 15:8 held high outside; the reference
        // is captured before detection is enabled, so no stale flag
        put(1'b1, 2'h0, LOC_ALT_EN, 16'h0000);
        put(1'b1, 2'h0, LOC_OUT_BUF, 16'hFF00);
        ext_en[0] = 16'hFF00;
        ext_val[0] = 16'hFF00;
        tick(3);
        rd(2'h0, LOC_LATCH, got);
        chk16(got, 16'hFF00);
        put(1'b1, 2'h0, LOC_KC_EN, 16'h8000);
        put(1'b1, 2'h0, LOC_KC_CTRL, 16'h0001);
        ext_val[0][14] = 1'b0;
        tick(6);
        chk1(kc_flag | wake, 1'b0);
        ext_val[0][14] = 1'b1;
        tick(3);
        ext_val[0][15] = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1 chk1(kc_flag, 1'b0);
        repeat (2) @(posedge i_sys_clk);
        #1 chk1(kc_flag & wake, 1'b1);
        @(posedge i_sys_clk);
        #1 chk1(kc_irq, 1'b1);
        #1 rd(2'h0, LOC_KC_CTRL, got);
        chk16(got, 16'h0003);
        put(1'b1, 2'h0, LOC_KC_CTRL, 16'h0003);
        tick(3);
        chk1(kc_flag | kc_irq, 1'b0);
        chk1(wake, 1'b1);
        rd(2'h0, LOC_LATCH, got);
        chk16(got, 16'h7F00);
        tick(3);
        chk1(wake, 1'b0);
        put(1'b1, 2'h0, LOC_KC_CTRL, 16'h0000);
        ext_val[0][15] = 1'b1;
        tick(6);
        chk1(kc_flag, 1'b1);
        chk1(kc_irq, 1'b0);
        // Bit 15 as 011 has no wake capability
        put(1'b1, 2'h0, LOC_KC_CTRL, 16'h0002);
        put(1'b1, 2'h0, LOC_ATTR, 16'h8000);
        tick(3);
        rd(2'h0, LOC_LATCH, got);
        ext_val[0][15] = 1'b0;
        tick(6);
        chk1(kc_flag | wake, 1'b0);
        // Reset in mid-run brings every pin back to floating input
        i_rst_b = 1'b0;
        #5 chk1(|{pad_oe, pull_up, pull_dn, alt_en, kc_flag}, 1'b0);
        chk1(kc_irq | wake | rd_valid, 1'b0);
        tick(2);
        i_rst_b = 1'b1;
        tick(1);
        rd(2'h2, LOC_ATTR, got);
        chk16(got, 16'hFFFF);
        rd(2'h2, LOC_DIR, got);
        chk16(got, 16'h0000);
        wrap_up();
    end
endmodule : gpk_port_tb

`default_nettype wire
